// >>> smbus_ctrl_pkg.sv
package smbus_ctrl_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam int NUM_REGS = 5;
  localparam logic [6:0] REG_FREQ_ENABLE_PLL_READBACK = 7'h00;
  localparam logic [6:0] REG_OUTPUT_ENABLE_LOW = 7'h01;
  localparam logic [6:0] REG_OUTPUT_ENABLE_MID = 7'h02;
  localparam logic [6:0] REG_RESERVED_A = 7'h03;
  localparam logic [6:0] REG_RESERVED_B = 7'h04;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int FREQ_STRAP_BIT = 0;
  localparam int OE_HIGH_LSB = 3;
  localparam int OE_HIGH_MSB = 5;
  localparam int PLL_MODE_LSB = 6;
  localparam int PLL_MODE_MSB = 7;
  localparam int NUM_OUTPUTS = 19;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [2:0] RST_OE_HIGH = 3'h7;
  localparam logic [7:0] RST_OE_LOW = 8'hff;
  localparam logic [7:0] RST_OE_MID = 8'hff;
  localparam logic [7:0] RST_RESERVED = 8'h00;

  // ****************************************************************
  // Protocol constants
  // ****************************************************************
  localparam int CMD_BYTE_MODE_BIT = 7;
  localparam logic [7:0] BLOCK_COUNT_MIN = 8'h01;
  localparam logic [7:0] BLOCK_COUNT_MAX = 8'h20;
  localparam logic [7:0] BLOCK_READ_COUNT = 8'h05;
  localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h6c;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_HZ = 20000000;
  localparam int HOLD_LIMIT_MS = 10;
  localparam int HOLD_LIMIT_CYC = (CLK_HZ / 1000) * HOLD_LIMIT_MS;
  localparam int STRAP_SETTLE_CYC = 2;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_CMD,
    ST_COUNT,
    ST_WDATA,
    ST_TX,
    ST_IGNORE
  } link_state_t;

endpackage

// >>> scl_shift_capture.sv
`timescale 1ns/1ps
module scl_shift_capture (
  input wire logic scl_clk,
  input wire logic sda_in,
  output logic [7:0] shift_byte
);

  // Data only; read by the system domain while the clock line is high and stable
  always_ff @(posedge scl_clk) begin
    shift_byte <= {shift_byte[6:0], sda_in};
  end

endmodule

// >>> ctrl_reg_bank.sv
`timescale 1ns/1ps
module ctrl_reg_bank
  import smbus_ctrl_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic wr_en,
  input wire logic [6:0] wr_index,
  input wire logic [7:0] wr_data,
  input wire logic [6:0] rd_index,
  output logic [7:0] rd_data,
  input wire logic freq_strap,
  input wire logic [1:0] pll_strap,
  output logic [NUM_OUTPUTS-1:0] enables
);

  logic [2:0] oe_high_r;
  logic [7:0] oe_low_r;
  logic [7:0] oe_mid_r;

  // ****************************************************************
  // Writable fields; read-only and reserved bits are never stored
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (srst) begin
      oe_high_r <= RST_OE_HIGH; // R13
      oe_low_r <= RST_OE_LOW; // R16
      oe_mid_r <= RST_OE_MID; // R17
    end else if (wr_en) begin
      case (wr_index)
        REG_FREQ_ENABLE_PLL_READBACK: oe_high_r <= wr_data[OE_HIGH_MSB:OE_HIGH_LSB]; // R21
        REG_OUTPUT_ENABLE_LOW: oe_low_r <= wr_data; // R16
        REG_OUTPUT_ENABLE_MID: oe_mid_r <= wr_data; // R17
        default: ;
      endcase
    end
  end

  // ****************************************************************
  // Registered read port
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (srst) begin
      rd_data <= 8'h00;
    end else begin
      case (rd_index)
        REG_FREQ_ENABLE_PLL_READBACK:
          rd_data <= {pll_strap, oe_high_r, 2'b00, freq_strap}; // R12 R13 R14 R15
        REG_OUTPUT_ENABLE_LOW: rd_data <= oe_low_r;
        REG_OUTPUT_ENABLE_MID: rd_data <= oe_mid_r;
        REG_RESERVED_A: rd_data <= RST_RESERVED; // R18
        REG_RESERVED_B: rd_data <= RST_RESERVED; // R18
        default: rd_data <= 8'h00;
      endcase
    end
  end

  assign enables = {oe_high_r, oe_mid_r, oe_low_r};

endmodule

// >>> smbus_output_control_regs.sv
`timescale 1ns/1ps
// Function
// R1: Byte access carries register index in command
// R2: Command bit 7 set byte, clear block
// R3: Byte read returns register data after restart
// R4: Host acks bytes, naks last, then stop
// R5: Block count must be 1 to 32
// R6: Block write starts at command low bits
// R7: Command zero starts block at register zero
// R8: Host sends command, count, then data bytes
// R9: Device acks every block write byte
// R10: Block read sends count then data bytes
// R11: Host acks block read bytes except last
// R12: Register 0 bit 0 returns frequency strap
// R13: Register 0 bits 3-5 enable outputs 16-18
// R14: Register 0 bits 6-7 return PLL strap
// R15: PLL readback always returns latched strap value
// R16: Register 1 enables outputs 0 to 7
// R17: Register 2 enables outputs 8 to 15
// R18: Registers 3 and 4 read zero
// R19: Never hold bus lines low over 10 ms
// R20: Power down releases bus, keeps registers
// R21: Index advances; read-only bits ignore writes
module smbus_output_control_regs
  import smbus_ctrl_pkg::*;
#(
  parameter int HOLD_LIMIT = HOLD_LIMIT_CYC,
  parameter logic [6:0] DEV_ADDR = DEV_ADDR_DEFAULT
)(
  input wire logic clk,
  input wire logic srst,
  input wire logic scl_clk,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_drive_n,
  output logic scl_out,
  output logic scl_drive_n,
  input wire logic power_down_n,
  input wire logic freq_select_strap,
  input wire logic [1:0] pll_bandwidth_strap,
  output logic [NUM_OUTPUTS-1:0] diff_clock_output_en
);

  localparam int HOLD_W = $clog2(HOLD_LIMIT + 1);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  logic scl_meta_r;
  logic scl_sync_r;
  logic scl_prev_r;
  logic sda_meta_r;
  logic sda_sync_r;
  logic sda_prev_r;
  logic pd_meta_r;
  logic pd_sync_r;
  logic freq_meta_r;
  logic freq_sync_r;
  logic [1:0] pll_meta_r;
  logic [1:0] pll_sync_r;
  logic [1:0] settle_cnt_r;
  logic freq_latched_r;
  logic [1:0] pll_latched_r;
  logic scl_rise;
  logic scl_fall;
  logic start_cond;
  logic stop_cond;
  logic hold_expired;
  logic bus_abort;
  logic [7:0] rx_byte;
  link_state_t state_r;
  link_state_t nxt_state_r;
  logic [3:0] bitcnt_r;
  logic block_r;
  logic [6:0] index_r;
  logic [5:0] remain_r;
  logic send_count_r;
  logic ack_r;
  logic [7:0] tx_r;
  logic [7:0] tx_nxt;
  logic drive_r;
  logic [HOLD_W-1:0] hold_cnt_r;
  logic wr_en;
  logic byte_done;
  logic ack_sample;
  logic byte_end;
  logic [7:0] rd_data;
  logic [NUM_OUTPUTS-1:0] enables;
  logic [NUM_OUTPUTS-1:0] oe_out_r;

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (srst) begin
      scl_meta_r <= 1'b1;
      scl_sync_r <= 1'b1;
      scl_prev_r <= 1'b1;
      sda_meta_r <= 1'b1;
      sda_sync_r <= 1'b1;
      sda_prev_r <= 1'b1;
    end else begin
      scl_meta_r <= scl_clk;
      scl_sync_r <= scl_meta_r;
      scl_prev_r <= scl_sync_r;
      sda_meta_r <= sda_in;
      sda_sync_r <= sda_meta_r;
      sda_prev_r <= sda_sync_r;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      pd_meta_r <= 1'b1;
      pd_sync_r <= 1'b1;
      freq_meta_r <= 1'b0;
      freq_sync_r <= 1'b0;
      pll_meta_r <= 2'b00;
      pll_sync_r <= 2'b00;
    end else begin
      pd_meta_r <= power_down_n;
      pd_sync_r <= pd_meta_r;
      freq_meta_r <= freq_select_strap;
      freq_sync_r <= freq_meta_r;
      pll_meta_r <= pll_bandwidth_strap;
      pll_sync_r <= pll_meta_r;
    end
  end

  // ****************************************************************
  // Strap capture once after reset release
  // ****************************************************************
  // Latched values are not touched again until reset, so readback stays the value captured after reset release
  always_ff @(posedge clk) begin
    if (srst) begin
      settle_cnt_r <= 2'b00;
      freq_latched_r <= 1'b0;
      pll_latched_r <= 2'b00;
    end else if (settle_cnt_r == STRAP_SETTLE_CYC[1:0]) begin
      settle_cnt_r <= settle_cnt_r + 2'b01;
      freq_latched_r <= freq_sync_r; // R12
      pll_latched_r <= pll_sync_r; // R14 R15
    end else if (settle_cnt_r < STRAP_SETTLE_CYC[1:0]) begin
      settle_cnt_r <= settle_cnt_r + 2'b01;
    end
  end

  // ****************************************************************
  // Bus events
  // ****************************************************************
  assign scl_rise = scl_sync_r & ~scl_prev_r;
  assign scl_fall = ~scl_sync_r & scl_prev_r;
  assign start_cond = scl_sync_r & scl_prev_r & sda_prev_r & ~sda_sync_r;
  assign stop_cond = scl_sync_r & scl_prev_r & ~sda_prev_r & sda_sync_r;
  assign hold_expired = drive_r && (hold_cnt_r == HOLD_W'(HOLD_LIMIT - 1));
  assign bus_abort = ~pd_sync_r | hold_expired;

  assign byte_done = scl_rise && (bitcnt_r == 4'd7) && (state_r != ST_TX)
                     && (state_r != ST_IDLE) && (state_r != ST_IGNORE);
  assign ack_sample = scl_rise && (bitcnt_r == 4'd8) && (state_r == ST_TX);
  assign byte_end = scl_fall && (bitcnt_r == 4'd9);

  // Shift register on the link clock; sampled here only while scl is high
  scl_shift_capture u_capture (
    .scl_clk(scl_clk),
    .sda_in(sda_in),
    .shift_byte(rx_byte)
  );

  assign wr_en = ~bus_abort && ~start_cond && ~stop_cond && byte_done
                 && (state_r == ST_WDATA) && (remain_r != 6'd0);

  // ****************************************************************
  // Transfer sequencing
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (srst) begin
      state_r <= ST_IDLE;
      nxt_state_r <= ST_IDLE;
      bitcnt_r <= 4'd0;
      block_r <= 1'b0;
      index_r <= 7'h00;
      remain_r <= 6'd0;
      send_count_r <= 1'b0;
      ack_r <= 1'b0;
    end else if (bus_abort) begin
      // Powered down: idle the link; hold limit expired: ignore until start or stop; register contents are kept
      state_r <= pd_sync_r ? ST_IGNORE : ST_IDLE; // R19 R20
      bitcnt_r <= 4'd0;
      ack_r <= 1'b0;
    end else if (start_cond) begin
      // Repeated start keeps command, index and mode for the read phase
      state_r <= ST_ADDR;
      bitcnt_r <= 4'd0;
      ack_r <= 1'b0;
    end else if (stop_cond) begin
      state_r <= ST_IDLE;
      bitcnt_r <= 4'd0;
      ack_r <= 1'b0;
    end else if (scl_rise && state_r != ST_IDLE && state_r != ST_IGNORE) begin
      bitcnt_r <= bitcnt_r + 4'd1;
      if (byte_done) begin
        case (state_r)
          ST_ADDR: begin
            if (rx_byte[7:1] == DEV_ADDR) begin
              ack_r <= 1'b1;
              nxt_state_r <= rx_byte[0] ? ST_TX : ST_CMD; // R3
              send_count_r <= rx_byte[0] & block_r; // R10
            end else begin
              ack_r <= 1'b0;
              nxt_state_r <= ST_IGNORE;
            end
          end
          ST_CMD: begin
            ack_r <= 1'b1; // R10
            index_r <= rx_byte[6:0]; // R1 R6 R7
            block_r <= ~rx_byte[CMD_BYTE_MODE_BIT]; // R2
            remain_r <= 6'd1;
            nxt_state_r <= rx_byte[CMD_BYTE_MODE_BIT] ? ST_WDATA : ST_COUNT; // R2
          end
          ST_COUNT: begin
            if (rx_byte >= BLOCK_COUNT_MIN && rx_byte <= BLOCK_COUNT_MAX) begin // R5
              ack_r <= 1'b1; // R9
              remain_r <= rx_byte[5:0]; // R8
              nxt_state_r <= ST_WDATA;
            end else begin
              ack_r <= 1'b0;
              nxt_state_r <= ST_IGNORE;
            end
          end
          ST_WDATA: begin
            if (remain_r != 6'd0) begin
              ack_r <= 1'b1; // R9
              index_r <= index_r + 7'd1; // R21
              remain_r <= remain_r - 6'd1;
              nxt_state_r <= ST_WDATA;
            end else begin
              // Bytes beyond the announced count are refused
              ack_r <= 1'b0;
              nxt_state_r <= ST_IGNORE;
            end
          end
          default: begin
            ack_r <= 1'b0;
            nxt_state_r <= ST_IGNORE;
          end
        endcase
      end
      if (ack_sample) begin
        if (sda_sync_r) begin
          nxt_state_r <= ST_IGNORE; // R4 R11
        end else begin
          nxt_state_r <= ST_TX;
          if (send_count_r) begin
            send_count_r <= 1'b0; // R10
          end else begin
            index_r <= index_r + 7'd1; // R21
          end
        end
      end
    end else if (byte_end && state_r != ST_IDLE && state_r != ST_IGNORE) begin
      bitcnt_r <= 4'd0;
      state_r <= nxt_state_r;
      ack_r <= 1'b0;
    end
  end

  // ****************************************************************
  // Transmit byte source
  // ****************************************************************
  // Block reads lead with the byte count, then register data
  assign tx_nxt = send_count_r ? BLOCK_READ_COUNT : rd_data; // R3 R10

  always_ff @(posedge clk) begin
    if (srst) begin
      tx_r <= 8'h00;
    end else if (byte_end) begin
      tx_r <= tx_nxt;
    end
  end

  // ****************************************************************
  // Data line drive, set only while scl is low; released at once on abort, start or stop
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (srst) begin
      drive_r <= 1'b0;
    end else if (bus_abort || start_cond || stop_cond) begin
      drive_r <= 1'b0; // R19 R20
    end else if (scl_fall) begin
      if (state_r == ST_IDLE || state_r == ST_IGNORE) begin
        drive_r <= 1'b0;
      end else if (bitcnt_r == 4'd8) begin
        drive_r <= (state_r != ST_TX) && ack_r; // R9 R10
      end else if (bitcnt_r == 4'd9) begin
        drive_r <= (nxt_state_r == ST_TX) && ~tx_nxt[7]; // R3
      end else if (state_r == ST_TX && bitcnt_r != 4'd0) begin
        drive_r <= ~tx_r[3'd7 - bitcnt_r[2:0]];
      end else begin
        drive_r <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Low-hold watchdog
  // ****************************************************************
  // Clock is never stretched; this bounds how long data may be held low
  always_ff @(posedge clk) begin
    if (srst) begin
      hold_cnt_r <= '0;
    end else if (drive_r && !hold_expired) begin
      hold_cnt_r <= hold_cnt_r + HOLD_W'(1); // R19
    end else begin
      hold_cnt_r <= '0;
    end
  end

  // ****************************************************************
  // Register bank and output enables
  // ****************************************************************
  ctrl_reg_bank u_regs (
    .clk(clk),
    .srst(srst),
    .wr_en(wr_en),
    .wr_index(index_r),
    .wr_data(rx_byte),
    .rd_index(index_r),
    .rd_data(rd_data),
    .freq_strap(freq_latched_r),
    .pll_strap(pll_latched_r),
    .enables(enables)
  );

  // Power-down forces every pair low/low but leaves the enable bits intact
  always_ff @(posedge clk) begin
    if (srst) begin
      oe_out_r <= '0;
    end else begin
      oe_out_r <= enables & {NUM_OUTPUTS{pd_sync_r}}; // R13 R16 R17 R20
    end
  end

  assign diff_clock_output_en = oe_out_r;
  assign sda_out = 1'b0;
  assign sda_drive_n = ~drive_r;
  assign scl_out = 1'b0;
  assign scl_drive_n = 1'b1; // R19

endmodule

// >>> smbus_output_control_regs_props.sv
`timescale 1ns/1ps
module ctrl_regs_props
  import smbus_ctrl_pkg::*;
#(
  parameter int HOLD_LIMIT = HOLD_LIMIT_CYC
)(
  input wire logic clk,
  input wire logic srst,
  input wire logic scl_clk,
  input wire logic sda_out,
  input wire logic sda_drive_n,
  input wire logic scl_out,
  input wire logic scl_drive_n,
  input wire logic power_down_n,
  input wire logic [NUM_OUTPUTS-1:0] diff_clock_output_en
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  // ********
  // Helpers
  // ********
  // Counts how long SDA is pulled low, so a stuck transfer shows up
  logic [31:0] hold_cnt_r;
  always_ff @(posedge clk) begin
    if (srst || sda_drive_n) begin
      hold_cnt_r <= '0;
    end else begin
      hold_cnt_r <= hold_cnt_r + 32'h0000_0001;
    end
  end
  // ********
  // Properties
  // ********
  property p_scl_free; scl_drive_n; endproperty
  property p_hold; hold_cnt_r <= HOLD_LIMIT + 4; endproperty
  property p_pd_oe; !power_down_n [*5] |-> diff_clock_output_en == '0; endproperty
  property p_pd_sda; !power_down_n [*5] |-> sda_drive_n; endproperty
  property p_fall_low; $fell(sda_drive_n) |-> !scl_clk; endproperty
  property p_rst_oe; $fell(srst) && power_down_n |-> ##[1:4] diff_clock_output_en == '1;
  endproperty
  property p_rst_sda; $fell(srst) |-> sda_drive_n [*2]; endproperty
  property p_od; !sda_drive_n |-> !sda_out; endproperty
  a_scl_free: assert property (p_scl_free) else $error("clock line pulled");
  a_hold: assert property (p_hold) else $error("data line held too long");
  a_pd_oe: assert property (p_pd_oe) else $error("outputs on in power down");
  a_pd_sda: assert property (p_pd_sda) else $error("data driven in power down");
  a_fall_low: assert property (p_fall_low) else $error("data fell with clock high");
  a_rst_oe: assert property (p_rst_oe) else $error("enables not set by reset");
  a_rst_sda: assert property (p_rst_sda) else $error("data driven after reset");
  a_od: assert property (p_od) else $error("data driven high");
  c_ack: cover property ($fell(sda_drive_n));
  c_pd: cover property (!power_down_n [*5]);
  c_hold: cover property (hold_cnt_r == HOLD_LIMIT - 1);
endmodule
bind smbus_output_control_regs ctrl_regs_props #(.HOLD_LIMIT(HOLD_LIMIT)) i_ctrl_regs_props (
  .clk(clk), .srst(srst), .scl_clk(scl_clk), .sda_out(sda_out), .sda_drive_n(sda_drive_n),
  .scl_out(scl_out), .scl_drive_n(scl_drive_n), .power_down_n(power_down_n),
  .diff_clock_output_en(diff_clock_output_en)
);

// >>> host_model.sv
`timescale 1ns/1ps
module host_model (
  input wire logic sda_drive_n,
  input wire logic sda_out,
  input wire logic scl_drive_n,
  input wire logic scl_out,
  output logic scl,
  output logic sda
);
  // ********
  // Open-drain lines with pull-ups
  // ********
  // Quarter bit, well above the device's synchroniser delay
  localparam time Q = 250ns;
  logic scl_r = 1'b1;
  logic sda_r = 1'b1;
  assign scl = scl_r & (scl_drive_n | scl_out);
  assign sda = sda_r & (sda_drive_n | sda_out);
  // Clock stands high between frames
  // Line changes land after the device's clock edge has sampled, so no race
  task automatic start_cond();
    sda_r <= 1'b1;
    #Q;
    scl_r <= 1'b1;
    #Q;
    sda_r <= 1'b0;
    #Q;
    scl_r <= 1'b0;
    #Q;
  endtask
  task automatic stop_cond();
    sda_r <= 1'b0;
    #Q;
    scl_r <= 1'b1;
    #Q;
    sda_r <= 1'b1;
    #Q;
  endtask
  task automatic put_bit(input logic b, output logic seen);
    sda_r <= b;
    #Q;
    scl_r <= 1'b1;
    #Q;
    seen = sda;
    #Q;
    scl_r <= 1'b0;
    #Q;
  endtask
  // Byte MSB first, then the acknowledge slot
  task automatic xfer(input logic [7:0] d, input logic ack_in, output logic [7:0] q,
                      output logic ack_seen);
    for (int i = 7; i >= 0; i--) begin
      put_bit(d[i], q[i]);
    end
    put_bit(ack_in, ack_seen);
  endtask
endmodule

// >>> tb_smbus_output_control_regs.sv
`timescale 1ns/1ps
module tb_smbus_output_control_regs
  import smbus_ctrl_pkg::*;
;
  localparam int HOLD = 400;
  // Strap pins, and the values the device should have latched from them
  logic freq_pin = 1'b1;
  logic [1:0] pll_pin = 2'b01;
  logic freq_lat = 1'b1;
  logic [1:0] pll_lat = 2'b01;
  typedef struct packed {
    logic [6:0] idx;
    logic [7:0] wdata;
    logic [7:0] rdata;
  } row_t;
  localparam row_t ROWS [8] = '{'{7'h00, 8'h00, 8'h41}, '{7'h00, 8'hff, 8'h79},
    '{7'h01, 8'ha5, 8'ha5}, '{7'h02, 8'h3c, 8'h3c}, '{7'h03, 8'hff, 8'h00},
    '{7'h04, 8'h5a, 8'h00}, '{7'h05, 8'hff, 8'h00}, '{7'h01, 8'h00, 8'h00}};
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic power_down_n = 1'b1;
  logic scl, sda, sda_out, sda_drive_n, scl_out, scl_drive_n;
  logic [NUM_OUTPUTS-1:0] diff_clock_output_en;
  logic [NUM_OUTPUTS-1:0] oe_m = '1;
  int checks = 0;
  int miscompares = 0;
  smbus_output_control_regs #(.HOLD_LIMIT(HOLD), .DEV_ADDR(DEV_ADDR_DEFAULT))
  i_smbus_output_control_regs (.clk(clk), .srst(srst), .scl_clk(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_drive_n(sda_drive_n), .scl_out(scl_out),
    .scl_drive_n(scl_drive_n), .power_down_n(power_down_n), .freq_select_strap(freq_pin),
    .pll_bandwidth_strap(pll_pin), .diff_clock_output_en(diff_clock_output_en));
  host_model i_host_model (.sda_drive_n(sda_drive_n), .sda_out(sda_out),
    .scl_drive_n(scl_drive_n), .scl_out(scl_out), .scl(scl), .sda(sda));
  // ********
  // Reference model and helpers
  // ********
  function automatic logic [7:0] reg_exp(input logic [6:0] i);
    case (i)
      7'h00: return {pll_lat, oe_m[18:16], 2'b00, freq_lat};
      7'h01: return oe_m[7:0];
      7'h02: return oe_m[15:8];
      default: return 8'h00;
    endcase
  endfunction
  task automatic apply(input logic [6:0] i, input logic [7:0] d);
    case (i)
      7'h00: oe_m[18:16] = d[5:3];
      7'h01: oe_m[7:0] = d;
      7'h02: oe_m[15:8] = d;
      default: ;
    endcase
  endtask
  task automatic clks(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  task automatic wrap_up();
    $display("checks=%0d miscompares=%0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic send(input logic [7:0] d, input logic ack);
    logic [7:0] q;
    logic a;
    i_host_model.xfer(d, 1'b1, q, a);
    check("ack", 32'(!ack), 32'(a));
  endtask
  task automatic recv(input logic last, input logic [7:0] exp);
    logic [7:0] q;
    logic a;
    i_host_model.xfer(8'hff, last, q, a);
    check("rdata", 32'(exp), 32'(q));
  endtask
  task automatic head(input logic [7:0] cmd);
    i_host_model.start_cond();
    send({DEV_ADDR_DEFAULT, 1'b0}, 1'b1);
    send(cmd, 1'b1);
  endtask
  task automatic byte_rw(input row_t r);
    head({1'b1, r.idx});
    send(r.wdata, 1'b1);
    i_host_model.stop_cond();
    apply(r.idx, r.wdata);
    head({1'b1, r.idx});
    i_host_model.start_cond();
    send({DEV_ADDR_DEFAULT, 1'b1}, 1'b1);
    recv(1'b1, r.rdata);
    i_host_model.stop_cond();
    clks(4);
    check("oe", 32'(oe_m), 32'(diff_clock_output_en));
  endtask
  task automatic blk_read();
    head(8'h00);
    i_host_model.start_cond();
    send({DEV_ADDR_DEFAULT, 1'b1}, 1'b1);
    recv(1'b0, BLOCK_READ_COUNT);
    for (int k = 0; k < 5; k++) begin
      recv(k == 4, reg_exp(7'(k)));
    end
    i_host_model.stop_cond();
  endtask
  task automatic blk_write(input logic [6:0] idx, input logic [7:0] n, input logic [7:0] d);
    logic ok;
    ok = n >= BLOCK_COUNT_MIN && n <= BLOCK_COUNT_MAX;
    head({1'b0, idx});
    send(n, ok);
    for (int k = 0; ok && k < n; k++) begin
      send(d + 8'(k) * 8'h11, 1'b1);
      apply(idx + 7'(k), d + 8'(k) * 8'h11);
    end
    i_host_model.stop_cond();
    blk_read();
  endtask
  // Address byte sent, host then holds the clock low in the acknowledge slot
  task automatic addr_stall();
    logic b;
    i_host_model.start_cond();
    for (int i = 7; i >= 0; i--) begin
      i_host_model.put_bit(i == 0 ? 1'b0 : DEV_ADDR_DEFAULT[i-1], b);
    end
  endtask
  // ********
  // Stimulus
  // ********
  initial begin
    forever #25 clk = ~clk;
  end
  initial begin
    #4ms;
    miscompares++;
    wrap_up();
  end
  initial begin
    int n;
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    clks(8);
    check("oe", 32'(oe_m), 32'(diff_clock_output_en));
    blk_read();
    foreach (ROWS[i]) begin
      byte_rw(ROWS[i]);
    end
    // Straps move after capture; readback keeps the old value until reset
    freq_pin <= 1'b0;
    pll_pin <= 2'b11;
    clks(8);
    blk_read();
    srst <= 1'b1;
    clks(3);
    srst <= 1'b0;
    oe_m = '1;
    freq_lat = 1'b0;
    pll_lat = 2'b11;
    clks(8);
    check("oe_rst", 32'(oe_m), 32'(diff_clock_output_en));
    blk_read();
    blk_write(7'h01, 8'h04, 8'h40);
    blk_write(7'h00, 8'h03, 8'h00);
    blk_write(7'h02, 8'h20, 8'h05);
    blk_write(7'h01, 8'h00, 8'h77);
    blk_write(7'h01, 8'h21, 8'h77);
    i_host_model.start_cond();
    send({DEV_ADDR_DEFAULT ^ 7'h01, 1'b0}, 1'b0);
    i_host_model.stop_cond();
    // Power down while the device pulls the acknowledge; contents kept, outputs off
    addr_stall();
    check("ack_pd", 32'h0000_0000, 32'(sda_drive_n));
    power_down_n <= 1'b0;
    clks(8);
    check("oe_pd", 32'h0000_0000, 32'(diff_clock_output_en));
    check("sda_pd", 32'h0000_0001, 32'(sda_drive_n));
    power_down_n <= 1'b1;
    clks(8);
    i_host_model.stop_cond();
    check("oe", 32'(oe_m), 32'(diff_clock_output_en));
    blk_read();
    // Host stalls with the address acknowledge pending
    addr_stall();
    n = 0;
    while (sda_drive_n !== 1'b1 && n < 1000) begin
      @(posedge clk);
      n++;
    end
    check("hold", 32'h0000_0001, 32'(n > HOLD - 30 && n <= HOLD + 10));
    if (n >= 1000) begin
      wrap_up();
    end
    i_host_model.stop_cond();
    blk_read();
    wrap_up();
  end
endmodule
